//--- design/hb_steer_cfg.svh
`ifndef HB_STEER_CFG_SVH
`define HB_STEER_CFG_SVH

// ************************************************************
// mode field encodings
// ************************************************************
`define MODE_PASSIVE_OFF   2'h0
`define MODE_LS_PWM        2'h1
`define MODE_HS_PWM        2'h2
`define MODE_ACTIVE_OFF    2'h3

// ************************************************************
// widths and defaults
// ************************************************************
`define BRIDGES            3
`define TIME_W             8
`define CLK_PERIOD_NS      4
`define SYNC_STAGES        2

`endif

//--- design/hb_steer_pkg.sv
package hb_steer_pkg;
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_PRE_A,
      PH_PRE_B,
      PH_MAIN
   } phase_e;

   typedef logic [7:0] time_t;
endpackage

//--- design/bridge_timer.sv
`timescale 1ns/100ps
`include "hb_steer_cfg.svh"

// ************************************************************
// per-bridge phase sequencer and switching time measurement
// ************************************************************
module bridge_timer #(
   parameter int TW = `TIME_W
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic          on_req,
   input  wire logic          off_req,
   input  wire logic          split_en,
   input  wire logic          short_cycle,
   input  wire logic          rise_done,
   input  wire logic          fall_done,
   input  wire logic [TW-1:0] pre_time,
   input  wire logic [TW-1:0] blank_time,
   input  wire logic [TW-1:0] ccp_act_time,
   output logic      [1:0]    cur_step_ff,
   output logic      [TW-1:0] rise_meas_ff,
   output logic      [TW-1:0] fall_meas_ff
);
   hb_steer_pkg::phase_e phase_ff;
   logic [TW-1:0] pcnt_ff;
   logic [TW-1:0] rcnt_ff;
   logic [TW-1:0] fcnt_ff;
   logic          rbusy_ff;
   logic          fbusy_ff;
   logic [TW-1:0] half_time;

   assign half_time = pre_time >> 1;

   // ************************************************************
   // pre-charge / pre-discharge phases
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_ff <= hb_steer_pkg::PH_IDLE;
         pcnt_ff  <= '0;
      end
      else if (ce)
      begin
         unique case (phase_ff)
            hb_steer_pkg::PH_IDLE:
               if (on_req || off_req)
               begin
                  phase_ff <= hb_steer_pkg::PH_PRE_A;
                  pcnt_ff  <= '0;
               end
            hb_steer_pkg::PH_PRE_A:
            begin
               pcnt_ff <= pcnt_ff + 1'b1;
               // one current for the whole window unless split
               if (pcnt_ff + 1'b1 >= pre_time)
                  phase_ff <= hb_steer_pkg::PH_MAIN;
               else if (split_en && (pcnt_ff + 1'b1 >= half_time))
                  phase_ff <= hb_steer_pkg::PH_PRE_B;
            end
            hb_steer_pkg::PH_PRE_B:
            begin
               pcnt_ff <= pcnt_ff + 1'b1;
               if (pcnt_ff + 1'b1 >= pre_time)
                  phase_ff <= hb_steer_pkg::PH_MAIN;
            end
            hb_steer_pkg::PH_MAIN:
               phase_ff <= hb_steer_pkg::PH_IDLE;
         endcase
      end
   end

   // current step select: 1 first part, 2 second part, 0 otherwise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cur_step_ff <= 2'h0;
      else if (ce)
         cur_step_ff <= (phase_ff == hb_steer_pkg::PH_PRE_A) ? 2'h1 :
                        (phase_ff == hb_steer_pkg::PH_PRE_B) ? 2'h2 : 2'h0;
   end

   // ************************************************************
   // rise / fall measurement
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rbusy_ff     <= 1'b0;
         rcnt_ff      <= '0;
         rise_meas_ff <= '0;
      end
      else if (ce)
      begin
         if (on_req)
         begin
            rbusy_ff <= 1'b1;
            rcnt_ff  <= '0;
         end
         else if (rbusy_ff)
         begin
            rcnt_ff <= rcnt_ff + 1'b1;
            if (short_cycle)
            begin
               rbusy_ff     <= 1'b0;
               rise_meas_ff <= '0;
            end
            else if (rise_done)
            begin
               rbusy_ff     <= 1'b0;
               rise_meas_ff <= rcnt_ff;
            end
            else if (rcnt_ff + 1'b1 >= blank_time)
            begin
               rbusy_ff     <= 1'b0;
               rise_meas_ff <= '0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fbusy_ff     <= 1'b0;
         fcnt_ff      <= '0;
         fall_meas_ff <= '0;
      end
      else if (ce)
      begin
         if (off_req)
         begin
            fbusy_ff <= 1'b1;
            fcnt_ff  <= '0;
         end
         else if (fbusy_ff)
         begin
            fcnt_ff <= fcnt_ff + 1'b1;
            if (short_cycle)
            begin
               fbusy_ff     <= 1'b0;
               fall_meas_ff <= '0;
            end
            else if (fall_done)
            begin
               fbusy_ff     <= 1'b0;
               fall_meas_ff <= fcnt_ff;
            end
            else if (fcnt_ff + 1'b1 >= ccp_act_time)
            begin
               fbusy_ff     <= 1'b0;
               fall_meas_ff <= '0;
            end
         end
      end
   end
endmodule // bridge_timer

//--- design/hb_pwm_steer.sv
`timescale 1ns/100ps
`include "hb_steer_cfg.svh"

//Function
//- mode 11 actively holds both switches off
//- split off: one current per phase
//- split on: two sub-intervals per phase
//- short on/off time: PWM switch active
//- short cycle: opposite switch stays off
//- report times of PWM or active switch
//- rise not ended in blank: zero
//- fall not ended in ccp: zero
//- both short: all times zero
//- six-input scheme: each switch own input
//- six-input mode 00: passive off
//- mode 01 no detect: low side active
//- mode 10 no detect: high side active
//- detect on: roles from switch node
//- mode 01 truth table of input pair
//- mode 10 truth table of input pair
//- inputs paired 1-2, 3-4, 5-6
//- three-input: inputs 1, 3, 5
//- three-input mode 01 and 10 behaviour
//- freewheel needs bit, enable, three-input
//- classify roles before each activation
module hb_pwm_steer #(
   parameter int NB = `BRIDGES,
   parameter int TW = `TIME_W
) (
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic              CE,
   input  wire logic [5:0]        PWM_IN,
   input  wire logic              INPUT_COUNT_SELECT,
   input  wire logic              ROLE_DETECT_ENABLE,
   input  wire logic              SPLIT_PRECHARGE_ENABLE,
   input  wire logic [NB-1:0]     BRIDGE_PWM_ENABLE,
   input  wire logic [NB-1:0]     ACTIVE_FREEWHEEL_ENABLE,
   input  wire logic [2*NB-1:0]   BRIDGE_MODE_SELECT,
   input  wire logic [NB-1:0]     NODE_ABOVE_HIGH,
   input  wire logic [NB-1:0]     NODE_BELOW_LOW,
   input  wire logic [NB-1:0]     RISE_DONE,
   input  wire logic [NB-1:0]     FALL_DONE,
   input  wire logic [TW-1:0]     PRECHARGE_TIME,
   input  wire logic [TW-1:0]     VDS_BLANK_TIME,
   input  wire logic [TW-1:0]     CCP_ACTIVE_TIME,
   input  wire logic [TW-1:0]     CCP_FREEWHEEL_TIME,
   output logic      [NB-1:0]     HIGH_SIDE_SWITCH,
   output logic      [NB-1:0]     LOW_SIDE_SWITCH,
   output logic      [NB-1:0]     ACTIVE_OFF,
   output logic      [NB-1:0]     ACTIVE_IS_HIGH,
   output logic      [2*NB-1:0]   CURRENT_STEP,
   output logic      [2*TW*NB-1:0] MEASURED_DELAY_STATUS
);
   logic [1:0] rst_sync_ff;
   logic       rst_n_i;
   logic [5:0] pwm_s1_ff;
   logic [5:0] pwm_s2_ff;

   // ************************************************************
   // reset release
   // ************************************************************
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n_i = rst_sync_ff[1];

   // ************************************************************
   // input synchroniser
   // ************************************************************
   always_ff @(posedge CLK or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pwm_s1_ff <= 6'h00;
         pwm_s2_ff <= 6'h00;
      end
      else if (CE)
      begin
         pwm_s1_ff <= PWM_IN;
         pwm_s2_ff <= pwm_s1_ff;
      end
   end

   // decode desired switch pair {hs, ls} for one bridge
   function automatic logic [1:0] steer(
      input logic [1:0] mode,
      input logic       six,
      input logic       en,
      input logic       afw,
      input logic       odd,
      input logic       even,
      input logic       short_c
   );
      logic [1:0] r;
      r = 2'b00;
      if (mode == `MODE_ACTIVE_OFF || mode == `MODE_PASSIVE_OFF)
         r = 2'b00;
      else if (!en)
         r = 2'b00;
      else if (six)
      begin
         // pair decoding; equal inputs keep both off
         if (odd != even)
         begin
            if (mode == `MODE_LS_PWM)
               r = odd ? 2'b01 : 2'b10;
            else
               r = odd ? 2'b10 : 2'b01;
         end
      end
      else if (mode == `MODE_LS_PWM)
         r = odd ? 2'b01 : 2'b00;
      else
      begin
         // freewheel only outside short cycles
         if (odd)
            r = 2'b10;
         else if (afw && !short_c)
            r = 2'b01;
      end
      return r;
   endfunction

   // ************************************************************
   // per-bridge steering
   // ************************************************************
   genvar b;
   generate
      for (b = 0; b < NB; b++)
      begin : g_br
         logic [1:0]    mode;
         logic          odd;
         logic          even;
         logic          afw;
         logic [1:0]    want;
         logic          prev_odd_ff;
         logic [TW-1:0] hi_cnt_ff;
         logic [TW-1:0] lo_cnt_ff;
         logic          short_on_ff;
         logic          short_off_ff;
         logic          short_c;
         logic          act_hi_ff;
         logic          on_req;
         logic          off_req;
         logic [1:0]    step;
         logic [TW-1:0] rise_m;
         logic [TW-1:0] fall_m;

         assign mode = BRIDGE_MODE_SELECT[2*b+1:2*b];
         assign odd  = pwm_s2_ff[2*b];
         assign even = pwm_s2_ff[2*b+1];
         assign afw  = ACTIVE_FREEWHEEL_ENABLE[b] & BRIDGE_PWM_ENABLE[b] &
                       ~INPUT_COUNT_SELECT;
         assign short_c = short_on_ff | short_off_ff;
         assign want = steer(mode, INPUT_COUNT_SELECT, BRIDGE_PWM_ENABLE[b],
                             afw, odd, even, short_c);
         assign on_req  = odd & ~prev_odd_ff;
         assign off_req = ~odd & prev_odd_ff;

         // edge memory of the controlling input
         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
               prev_odd_ff <= 1'b0;
            else if (CE)
               prev_odd_ff <= odd;
         end

         // widths saturate so a stuck input never wraps back to short
         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
               hi_cnt_ff <= '0;
            else if (CE)
            begin
               if (odd)
                  hi_cnt_ff <= (hi_cnt_ff == '1) ? hi_cnt_ff : hi_cnt_ff + 1'b1;
               else
                  hi_cnt_ff <= '0;
            end
         end

         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
               lo_cnt_ff <= '0;
            else if (CE)
            begin
               if (!odd)
                  lo_cnt_ff <= (lo_cnt_ff == '1) ? lo_cnt_ff : lo_cnt_ff + 1'b1;
               else
                  lo_cnt_ff <= '0;
            end
         end

         // last measured widths; a short pulse gives up role detection
         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               short_on_ff  <= 1'b0;
               short_off_ff <= 1'b0;
            end
            else if (CE)
            begin
               if (off_req)
                  short_on_ff <= (hi_cnt_ff < CCP_FREEWHEEL_TIME);
               if (on_req)
                  short_off_ff <= (lo_cnt_ff < CCP_ACTIVE_TIME);
            end
         end

         // role of the switches, sampled right before activation
         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
               act_hi_ff <= 1'b0;
            else if (CE && on_req)
            begin
               if (short_c || !ROLE_DETECT_ENABLE)
                  act_hi_ff <= (mode == `MODE_HS_PWM);
               else if (NODE_ABOVE_HIGH[b])
                  act_hi_ff <= 1'b0;
               else if (NODE_BELOW_LOW[b])
                  act_hi_ff <= 1'b1;
               else
                  act_hi_ff <= (mode == `MODE_HS_PWM);
            end
         end

         // break before make; never both on
         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               HIGH_SIDE_SWITCH[b] <= 1'b0;
               LOW_SIDE_SWITCH[b]  <= 1'b0;
            end
            else if (CE)
            begin
               HIGH_SIDE_SWITCH[b] <= want[1] & ~LOW_SIDE_SWITCH[b] & ~want[0];
               LOW_SIDE_SWITCH[b]  <= want[0] & ~HIGH_SIDE_SWITCH[b] & ~want[1];
            end
         end

         // active hold is its own driver state, not merely both off
         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
               ACTIVE_OFF[b] <= 1'b0;
            else if (CE)
               ACTIVE_OFF[b] <= (mode == `MODE_ACTIVE_OFF);
         end

         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
               ACTIVE_IS_HIGH[b] <= 1'b0;
            else if (CE)
               ACTIVE_IS_HIGH[b] <= act_hi_ff;
         end

         // measures whichever switch is the active one
         bridge_timer #(
            .TW (TW)
         ) u_timer (
            .clk          (CLK),
            .rst_n        (rst_n_i),
            .ce           (CE),
            .on_req       (on_req & BRIDGE_PWM_ENABLE[b]),
            .off_req      (off_req & BRIDGE_PWM_ENABLE[b]),
            .split_en     (SPLIT_PRECHARGE_ENABLE),
            .short_cycle  (short_on_ff & short_off_ff),
            .rise_done    (RISE_DONE[b]),
            .fall_done    (FALL_DONE[b]),
            .pre_time     (PRECHARGE_TIME),
            .blank_time   (VDS_BLANK_TIME),
            .ccp_act_time (CCP_ACTIVE_TIME),
            .cur_step_ff  (step),
            .rise_meas_ff (rise_m),
            .fall_meas_ff (fall_m)
         );

         always_ff @(posedge CLK or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               CURRENT_STEP[2*b+1:2*b]                <= 2'h0;
               MEASURED_DELAY_STATUS[2*TW*b +: 2*TW]  <= '0;
            end
            else if (CE)
            begin
               CURRENT_STEP[2*b+1:2*b]                <= step;
               MEASURED_DELAY_STATUS[2*TW*b +: 2*TW]  <= {fall_m, rise_m};
            end
         end
      end
   endgenerate
endmodule // hb_pwm_steer

//--- test/hb_steer_properties.sv
`timescale 1ns/100ps
// ************************************************************
// port-level checks of the steering block
// ************************************************************
module hb_steer_properties #(
   parameter int NB = 3
) (
   input wire logic            CLK,
   input wire logic            RST_N,
   input wire logic [5:0]      PWM_IN,
   input wire logic            INPUT_COUNT_SELECT,
   input wire logic            SPLIT_PRECHARGE_ENABLE,
   input wire logic [NB-1:0]   BRIDGE_PWM_ENABLE,
   input wire logic [NB-1:0]   ACTIVE_FREEWHEEL_ENABLE,
   input wire logic [2*NB-1:0] BRIDGE_MODE_SELECT,
   input wire logic [NB-1:0]   HIGH_SIDE_SWITCH,
   input wire logic [NB-1:0]   LOW_SIDE_SWITCH,
   input wire logic [NB-1:0]   ACTIVE_OFF,
   input wire logic [2*NB-1:0] CURRENT_STEP
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // repetitions cover the 2-flop input sync plus the output register
   wire [1:0] m0  = BRIDGE_MODE_SELECT[1:0];
   wire [1:0] m2  = BRIDGE_MODE_SELECT[5:4];
   wire       hs0 = HIGH_SIDE_SWITCH[0];
   wire       ls0 = LOW_SIDE_SWITCH[0];
   wire       six = INPUT_COUNT_SELECT;
   wire       hs_req0  = six && BRIDGE_PWM_ENABLE[0] && m0 == 2'h2 && PWM_IN[1:0] == 2'h1;
   wire       fw_idle2 = !six && m2 == 2'h2 && !ACTIVE_FREEWHEEL_ENABLE[2] && !PWM_IN[4];
   never_both_a: assert property ((HIGH_SIDE_SWITCH & LOW_SIDE_SWITCH) == '0)
      else $error("bridge with both switches on");
   active_hold_a: assert property ((m0 == 2'h3) [*4] |-> ACTIVE_OFF[0] && !hs0 && !ls0)
      else $error("mode 3 not actively off");
   passive_off_a: assert property ((m0 == 2'h0) [*4] |-> !ACTIVE_OFF[0] && !hs0 && !ls0)
      else $error("mode 0 not passively off");
   equal_pair_a: assert property ((six && PWM_IN[0] == PWM_IN[1]) [*6] |-> !hs0 && !ls0)
      else $error("equal pair switched a side on");
   hs_make_a: assert property (hs_req0 [*8] |-> ##[0:8] hs0)
      else $error("high side not made");
   ls_pwm_low_a: assert property ((!six && m0 == 2'h1 && !PWM_IN[0]) [*6] |-> !hs0 && !ls0)
      else $error("low-side mode with input low not off");
   hs_blocked_a: assert property ((!six && m0 == 2'h1) [*6] |-> !hs0)
      else $error("high side on in low-side mode");
   no_afw_low_a: assert property (fw_idle2 [*6] |-> !LOW_SIDE_SWITCH[2])
      else $error("freewheel without its enable");
   single_step_a: assert property ((!SPLIT_PRECHARGE_ENABLE) [*8] |-> CURRENT_STEP[3:2] != 2'h2)
      else $error("second current step while split off");
   cover property (six && m0 == 2'h2 && hs0);
   cover property (ACTIVE_OFF[0]);
   cover property (SPLIT_PRECHARGE_ENABLE && CURRENT_STEP[3:2] == 2'h2);
endmodule // hb_steer_properties

//--- test/pwm_host.sv
`timescale 1ns/100ps
// ************************************************************
// controller side: drives the six PWM lines
// ************************************************************
module pwm_host (
   input  wire logic       clk,
   output logic      [5:0] pwm
);
   initial pwm = 6'h00;
   task automatic drive(input logic [5:0] v, input int n);
      @(posedge clk);
      pwm <= v;
      repeat (n) @(posedge clk);
   endtask
   // toggles only the selected lines, the rest keep their level
   task automatic pulse(input logic [5:0] sel, input int on_n, input int off_n, input int k);
      repeat (k)
      begin
         drive(pwm | sel, on_n);
         drive(pwm & ~sel, off_n);
      end
   endtask
endmodule // pwm_host

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        ics   = 1'b0;
   logic        det   = 1'b0;
   logic        split = 1'b0;
   logic [2:0]  ben   = 3'h0;
   logic [2:0]  afw   = 3'h0;
   logic [5:0]  mode  = 6'h00;
   logic [2:0]  above = 3'h0;
   logic [2:0]  below = 3'h0;
   logic [2:0]  rdone = 3'h0;
   logic [2:0]  fdone = 3'h0;
   logic [5:0]  pwm;
   logic [2:0]  hs, ls, aoff, ahigh;
   logic [5:0]  step;
   logic [47:0] stat;
   int          mismatches  = 0;
   int          check_count = 0;
   always #2 clk = ~clk;
   hb_pwm_steer hb_pwm_steer_inst (
      .CLK(clk), .RST_N(rst_n), .CE(1'b1), .PWM_IN(pwm), .INPUT_COUNT_SELECT(ics),
      .ROLE_DETECT_ENABLE(det), .SPLIT_PRECHARGE_ENABLE(split), .BRIDGE_PWM_ENABLE(ben),
      .ACTIVE_FREEWHEEL_ENABLE(afw), .BRIDGE_MODE_SELECT(mode), .NODE_ABOVE_HIGH(above),
      .NODE_BELOW_LOW(below), .RISE_DONE(rdone), .FALL_DONE(fdone),
      .PRECHARGE_TIME(8'h08), .VDS_BLANK_TIME(8'h06), .CCP_ACTIVE_TIME(8'h04),
      .CCP_FREEWHEEL_TIME(8'h04), .HIGH_SIDE_SWITCH(hs), .LOW_SIDE_SWITCH(ls),
      .ACTIVE_OFF(aoff), .ACTIVE_IS_HIGH(ahigh), .CURRENT_STEP(step),
      .MEASURED_DELAY_STATUS(stat)
   );
   pwm_host pwm_host_inst (.clk(clk), .pwm(pwm));
   // ************************************************************
   // checking and verdict
   // ************************************************************
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic test_six_truth();
      logic [1:0] c [3];
      logic [2:0] eh, el;
      for (int m = 1; m <= 2; m++)
         for (int k = 0; k < 4; k++)
         begin
            for (int b = 0; b < 3; b++)
            begin
               c[b] = 2'((k + b) % 4);
               eh[b] = (m == 2) ? (c[b] == 2'h1) : (c[b] == 2'h2);
               el[b] = (m == 2) ? (c[b] == 2'h2) : (c[b] == 2'h1);
            end
            @(posedge clk);
            ics <= 1'b1;
            ben <= 3'h7;
            mode <= {3{2'(m)}};
            pwm_host_inst.drive({c[2], c[1], c[0]}, 16);
            check_val("six hs", 16'(eh), 16'(hs));
            check_val("six ls", 16'(el), 16'(ls));
            if (k == 3)
               check_val("role", (m == 2) ? 16'h0007 : 16'h0000, 16'(ahigh));
         end
      $display("done: six-input table");
   endtask
   task automatic test_off_modes();
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         ics <= 1'(s);
         mode <= 6'h33;
         afw <= 3'h7;
         pwm_host_inst.drive(6'h15, 16);
         check_val("off hs", 16'h0000, 16'(hs));
         check_val("off ls", 16'h0000, 16'(ls));
         check_val("active off", 16'h0005, 16'(aoff));
      end
      $display("done: off modes");
   endtask
   task automatic test_three();
      @(posedge clk);
      ics <= 1'b0;
      afw <= 3'h3;
      mode <= 6'h29;
      // even lines held high: they must be ignored here
      pwm_host_inst.drive(6'h3F, 20);
      pwm_host_inst.drive(6'h2A, 20);
      pwm_host_inst.drive(6'h3F, 20);
      check_val("three hs", 16'h0006, 16'(hs));
      check_val("three ls", 16'h0001, 16'(ls));
      pwm_host_inst.drive(6'h2A, 20);
      check_val("three hs", 16'h0000, 16'(hs));
      check_val("three ls", 16'h0002, 16'(ls));
      check_val("role", 16'h0006, 16'(ahigh));
      for (int b = 0; b < 3; b++)
         check_val("status", 16'h0000, stat[16*b +: 16]);
      @(posedge clk);
      det <= 1'b1;
      below <= 3'h7;
      pwm_host_inst.pulse(6'h15, 20, 20, 2);
      check_val("role", 16'h0007, 16'(ahigh));
      @(posedge clk);
      below <= 3'h0;
      above <= 3'h7;
      pwm_host_inst.pulse(6'h15, 20, 20, 2);
      check_val("role", 16'h0000, 16'(ahigh));
      @(posedge clk);
      det <= 1'b0;
      above <= 3'h0;
      $display("done: three-input");
   endtask
   task automatic test_split();
      logic seen2;
      for (int s = 0; s < 2; s++)
      begin
         seen2 = 1'b0;
         @(posedge clk);
         split <= 1'(s);
         repeat (12) @(posedge clk);
         fork
            pwm_host_inst.pulse(6'h04, 20, 20, 2);
            repeat (80)
            begin
               @(negedge clk);
               seen2 |= (step[3:2] == 2'h2);
            end
         join
         check_val("second step", 16'(s), 16'(seen2));
      end
      $display("done: split pre-phase");
   endtask
   task automatic test_measure();
      // bridge 1 only; edge ends seen 4 edges after rise start, 3 after fall start
      pwm_host_inst.drive(6'h2E, 6);
      rdone <= 3'h2;
      pwm_host_inst.drive(6'h2A, 5);
      fdone <= 3'h2;
      repeat (4) @(posedge clk);
      check_val("measured", 16'h0203, stat[16 +: 16]);
      $display("done: measurement");
   endtask
   task automatic test_short();
      logic ls_seen;
      ls_seen = 1'b0;
      @(posedge clk);
      // no edge end seen: only the short-cycle rule can clear the old rise value
      rdone <= 3'h0;
      fdone <= 3'h0;
      pwm_host_inst.pulse(6'h15, 2, 2, 4);
      fork
         pwm_host_inst.pulse(6'h15, 2, 2, 8);
         repeat (30)
         begin
            @(negedge clk);
            ls_seen |= ls[1];
         end
      join
      check_val("short fw", 16'h0000, 16'(ls_seen));
      for (int b = 0; b < 3; b++)
         check_val("short status", 16'h0000, stat[16*b +: 16]);
      $display("done: short cycles");
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      test_six_truth();
      test_off_modes();
      test_three();
      test_split();
      test_measure();
      test_short();
      give_verdict();
   end
   // tests need about 750 cycles; allow a wide margin
   initial
   begin
      #(6000 * 4);
      mismatches++;
      give_verdict();
   end
endmodule // testbench
bind hb_pwm_steer hb_steer_properties #(.NB(NB)) hb_steer_properties_inst (
   .CLK(CLK), .RST_N(RST_N), .PWM_IN(PWM_IN), .INPUT_COUNT_SELECT(INPUT_COUNT_SELECT),
   .SPLIT_PRECHARGE_ENABLE(SPLIT_PRECHARGE_ENABLE), .BRIDGE_PWM_ENABLE(BRIDGE_PWM_ENABLE),
   .ACTIVE_FREEWHEEL_ENABLE(ACTIVE_FREEWHEEL_ENABLE), .BRIDGE_MODE_SELECT(BRIDGE_MODE_SELECT),
   .HIGH_SIDE_SWITCH(HIGH_SIDE_SWITCH), .LOW_SIDE_SWITCH(LOW_SIDE_SWITCH),
   .ACTIVE_OFF(ACTIVE_OFF), .CURRENT_STEP(CURRENT_STEP)
);
